// file: rbcs_board.sv
// Board model: reset button, test reset, straps and clock mode pin
`timescale 1ns/1ps
module rbcs_board
(
  input wire logic clk,
  input wire logic press,
  input wire logic keep_debug,
  input wire logic [3:0] straps,
  output logic reset_pin_n,
  output logic test_reset_n,
  output logic [3:0] pins
);
  // ********************
  // Board pins
  // ********************
  always_ff @(posedge clk)
  begin
    reset_pin_n <= !press;
    test_reset_n <= !(press && !keep_debug);
    pins <= straps; // Straps only move while reset is held
  end
endmodule

// file: rbcs_checker.sv
// Checker: reset release, boot latch and register effects
`timescale 1ns/1ps
module rbcs_checker
  import rbcs_pkg::*;
#(
  parameter int RELEASE_CYCLES = RBCS_RELEASE_CYCLES,
  parameter int POR_CYCLES = RBCS_POR_CYCLES
)
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic POR_N,
  input wire logic RESET_PIN_N,
  input wire logic BOOT_SOURCE_STRAP,
  input wire logic ADDRESS_WIDTH_STRAP,
  input wire logic FLASH_SECURED,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RESET_STATE_OUT_N,
  input wire logic INT_RESET_N,
  input wire logic BOOT_EXTERNAL,
  input wire logic WIDE_ADDRESS,
  input wire logic [4:0] ADDRESS_LINES,
  input wire logic RESET_PIN_PULLUP_EN,
  input wire logic OSC_HIGH_SWING_SELECT
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Five cycles covers the two-flop sync plus the output flop, which is fed from state_d
  property p_hold; !RESET_PIN_N [*5] |-> !INT_RESET_N; endproperty
  a_hold: assert property (p_hold) else $error("pin reset missed");
  property p_follow; RESET_STATE_OUT_N == INT_RESET_N; endproperty
  a_follow: assert property (p_follow) else $error("reset out off");
  property p_early; $rose(INT_RESET_N) |-> $past(RESET_PIN_N, 5); endproperty
  a_early: assert property (p_early) else $error("early release");
  property p_por; !POR_N [*5] |-> !INT_RESET_N; endproperty
  a_por: assert property (p_por) else $error("power-on reset missed");
  property p_boot; $rose(INT_RESET_N) |->
    BOOT_EXTERNAL == (BOOT_SOURCE_STRAP && !FLASH_SECURED); endproperty
  a_boot: assert property (p_boot) else $error("boot mode wrong");
  property p_wide; $rose(INT_RESET_N) |->
    WIDE_ADDRESS == (BOOT_EXTERNAL && ADDRESS_WIDTH_STRAP) &&
    ADDRESS_LINES == (WIDE_ADDRESS ? 5'h14 : 5'h10); endproperty
  a_wide: assert property (p_wide) else $error("width wrong");
  property p_pullup; WR && ADDR == RBCS_OFF_PULL_OFF && INT_RESET_N |-> ##2
    RESET_PIN_PULLUP_EN == !$past(WDATA[RBCS_PULL_RESET_BIT], 2); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_swing; WR && ADDR == RBCS_OFF_OSC_CTRL && INT_RESET_N |-> ##2
    OSC_HIGH_SWING_SELECT == $past(WDATA[RBCS_OSC_SWING_BIT], 2); endproperty
  a_swing: assert property (p_swing) else $error("swing bit wrong");
endmodule

bind rbcs_top rbcs_checker #(.RELEASE_CYCLES(RELEASE_CYCLES),
  .POR_CYCLES(POR_CYCLES)) u_checker (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .POR_N(POR_N), .RESET_PIN_N(RESET_PIN_N),
  .BOOT_SOURCE_STRAP(BOOT_SOURCE_STRAP),
  .ADDRESS_WIDTH_STRAP(ADDRESS_WIDTH_STRAP), .FLASH_SECURED(FLASH_SECURED),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RESET_STATE_OUT_N(RESET_STATE_OUT_N),
  .INT_RESET_N(INT_RESET_N), .BOOT_EXTERNAL(BOOT_EXTERNAL),
  .WIDE_ADDRESS(WIDE_ADDRESS), .ADDRESS_LINES(ADDRESS_LINES),
  .RESET_PIN_PULLUP_EN(RESET_PIN_PULLUP_EN),
  .OSC_HIGH_SWING_SELECT(OSC_HIGH_SWING_SELECT));

// file: rbcs_pkg.sv
// Package: constants and carrier types for reset, boot and clock select
package rbcs_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] RBCS_OFF_PULL_OFF = 4'h0;
  localparam logic [3:0] RBCS_OFF_OSC_CTRL = 4'h1;
  localparam logic [3:0] RBCS_OFF_STATUS = 4'h2;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RBCS_PULL_RESET_BIT = 0;
  localparam int RBCS_PULL_BOOT_BIT = 1;
  localparam int RBCS_PULL_AW_BIT = 2;
  localparam int RBCS_OSC_SWING_BIT = 0;
  localparam logic [15:0] RBCS_PULL_OFF_MASK = 16'h0007;
  localparam logic [15:0] RBCS_OSC_CTRL_MASK = 16'h0001;
  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [15:0] RBCS_PULL_OFF_RST = 16'h0000;
  localparam logic [15:0] RBCS_OSC_CTRL_RST = 16'h0000;
  localparam int RBCS_RELEASE_CYCLES = 32;
  localparam int RBCS_POR_CYCLES = 16;
  localparam int RBCS_ADDR_LINES_NARROW = 16;
  localparam int RBCS_ADDR_LINES_WIDE = 20;

  typedef enum logic [1:0]
  {
    RBCS_ST_POR = 2'b00,
    RBCS_ST_HOLD = 2'b01,
    RBCS_ST_COUNT = 2'b10,
    RBCS_ST_RUN = 2'b11
  } rbcs_state_t;

  typedef struct packed
  {
    logic boot_external;
    logic wide_address;
    logic flash_secured;
  } rbcs_boot_t;

  typedef struct packed
  {
    logic reset_pin_pullup_off;
    logic boot_strap_pullup_off;
    logic address_width_pullup_off;
  } rbcs_pullup_t;
endpackage

// file: rbcs_top.sv
// Reset sequencing, boot strap latching and oscillator swing select
`timescale 1ns/1ps
// ****************************************************************
// Reset, boot and clock select block
// ****************************************************************
module rbcs_top
  import rbcs_pkg::*;
#(
  parameter int RELEASE_CYCLES = RBCS_RELEASE_CYCLES,
  parameter int POR_CYCLES = RBCS_POR_CYCLES
)
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic POR_N,
  input wire logic RESET_PIN_N,
  input wire logic BOOT_SOURCE_STRAP,
  input wire logic ADDRESS_WIDTH_STRAP,
  input wire logic FLASH_SECURED,
  input wire logic CLOCK_MODE_INPUT,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic RESET_STATE_OUT_N,
  output logic INT_RESET_N,
  output logic BOOT_EXTERNAL,
  output logic WIDE_ADDRESS,
  output logic [4:0] ADDRESS_LINES,
  output logic RESET_PIN_PULLUP_EN,
  output logic BOOT_STRAP_PULLUP_EN,
  output logic ADDRESS_WIDTH_PULLUP_EN,
  output logic OSC_HIGH_SWING_SELECT,
  output logic EXT_CLOCK_MODE
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins are asynchronous to SYS_CLK: two stages before any use
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] pins_raw;
  logic rst_pin_n_s;
  logic boot_strap_s;
  logic aw_strap_s;
  logic secured_s;
  logic clock_mode_s;

  assign pins_raw = {CLOCK_MODE_INPUT, FLASH_SECURED, ADDRESS_WIDTH_STRAP,
                     BOOT_SOURCE_STRAP, RESET_PIN_N};
  assign rst_pin_n_s = sync2_q[0];
  assign boot_strap_s = sync2_q[1];
  assign aw_strap_s = sync2_q[2];
  assign secured_s = sync2_q[3];
  assign clock_mode_s = sync2_q[4];

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // Power-on reset stretch
  // ****************************************************************
  // POR_N is the analog detector; stretched so it always wins once
  logic [1:0] por_sync_q;
  logic [15:0] por_cnt_q;
  logic [15:0] por_cnt_d;
  logic por_done;

  assign por_done = (por_cnt_q == 16'(POR_CYCLES));
  assign por_cnt_d = por_done ? por_cnt_q : por_cnt_q + 16'h0001;

  always_ff @(posedge SYS_CLK or negedge POR_N)
  begin
    if (!POR_N)
    begin
      por_sync_q <= 2'h0;
      por_cnt_q <= 16'h0000;
    end
    else
    begin
      por_sync_q <= {por_sync_q[0], 1'b1};
      por_cnt_q <= por_sync_q[1] ? por_cnt_d : 16'h0000;
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  rbcs_state_t state_q;
  rbcs_state_t state_d;
  logic [15:0] rel_cnt_q;
  logic [15:0] rel_cnt_d;
  logic rel_done;
  logic hold_reset;

  // Either source holds the chip; pin is independent of power-on
  assign hold_reset = !rst_pin_n_s || !por_done;
  // Ends one short: leaving COUNT takes the final cycle
  assign rel_done = (rel_cnt_q == 16'(RELEASE_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    rel_cnt_d = rel_cnt_q;
    case (state_q)
      RBCS_ST_POR:
      begin
        rel_cnt_d = 16'h0000;
        if (por_done)
          state_d = RBCS_ST_HOLD;
      end
      RBCS_ST_HOLD:
      begin
        rel_cnt_d = 16'h0000;
        if (!hold_reset)
          state_d = RBCS_ST_COUNT;
      end
      RBCS_ST_COUNT:
      begin
        rel_cnt_d = rel_cnt_q + 16'h0001;
        if (rel_done)
          state_d = RBCS_ST_RUN;
      end
      RBCS_ST_RUN:
        state_d = RBCS_ST_RUN;
      default:
        state_d = RBCS_ST_POR;
    endcase
    // Any reset re-entry restarts the whole count
    if (hold_reset && state_q != RBCS_ST_POR)
    begin
      state_d = RBCS_ST_HOLD;
      rel_cnt_d = 16'h0000;
    end
  end

  logic in_reset;
  logic releasing;
  logic capture;
  // From state_d so outputs rise on the edge that enters RUN
  assign in_reset = (state_d != RBCS_ST_RUN);
  assign releasing = (state_q == RBCS_ST_HOLD) && (state_d == RBCS_ST_COUNT);
  assign capture = releasing;

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= RBCS_ST_POR;
      rel_cnt_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      rel_cnt_q <= rel_cnt_d;
    end
  end

  // ****************************************************************
  // Boot mode latch
  // ****************************************************************
  rbcs_boot_t boot_q;
  rbcs_boot_t boot_d;
  // Secured flash forbids external boot and narrows the bus
  assign boot_d.flash_secured = secured_s;
  assign boot_d.boot_external = boot_strap_s && !secured_s;
  assign boot_d.wide_address = boot_strap_s && !secured_s
                               && aw_strap_s;

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      boot_q <= '0;
    else if (capture)
      boot_q <= boot_d;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Software state is cleared by every internal reset
  logic [15:0] pullup_off_q;
  logic [15:0] osc_ctrl_q;
  logic [15:0] status_w;
  logic [15:0] rdata_d;
  logic wr_pullup_off;
  logic wr_osc_ctrl;
  logic sw_en;

  // One compare shared by the write strobes and the read mux
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] offset);
    reg_hit = (addr == offset);
  endfunction

  assign sw_en = (state_q == RBCS_ST_RUN);
  assign wr_pullup_off = WR && sw_en && reg_hit(ADDR, RBCS_OFF_PULL_OFF);
  assign wr_osc_ctrl = WR && sw_en && reg_hit(ADDR, RBCS_OFF_OSC_CTRL);
  // Only the swing bit exists; no relaxation oscillator controls
  assign status_w = {11'h000, clock_mode_s, boot_q.flash_secured,
                     boot_q.wide_address, boot_q.boot_external,
                     sw_en};
  assign rdata_d = !RD ? 16'h0000 :
                   reg_hit(ADDR, RBCS_OFF_PULL_OFF) ? pullup_off_q :
                   reg_hit(ADDR, RBCS_OFF_OSC_CTRL) ? osc_ctrl_q :
                   reg_hit(ADDR, RBCS_OFF_STATUS) ? status_w : 16'h0000;

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pullup_off_q <= RBCS_PULL_OFF_RST;
      osc_ctrl_q <= RBCS_OSC_CTRL_RST;
      RDATA <= 16'h0000;
    end
    else
    begin
      // The clear wins over writes: sw_en comes from state_q and can still be high on the first reset cycle
      if (in_reset)
      begin
        pullup_off_q <= RBCS_PULL_OFF_RST;
        osc_ctrl_q <= RBCS_OSC_CTRL_RST;
      end
      else
      begin
        if (wr_pullup_off)
          pullup_off_q <= WDATA & RBCS_PULL_OFF_MASK;
        if (wr_osc_ctrl)
          osc_ctrl_q <= WDATA & RBCS_OSC_CTRL_MASK;
      end
      RDATA <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  rbcs_pullup_t pull_off;
  // Enables are active high, so the disable bits are inverted below
  assign pull_off.reset_pin_pullup_off = pullup_off_q[RBCS_PULL_RESET_BIT];
  assign pull_off.boot_strap_pullup_off = pullup_off_q[RBCS_PULL_BOOT_BIT];
  assign pull_off.address_width_pullup_off = pullup_off_q[RBCS_PULL_AW_BIT];

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RESET_STATE_OUT_N <= 1'b0;
      INT_RESET_N <= 1'b0;
      BOOT_EXTERNAL <= 1'b0;
      WIDE_ADDRESS <= 1'b0;
      ADDRESS_LINES <= 5'(RBCS_ADDR_LINES_NARROW);
      RESET_PIN_PULLUP_EN <= 1'b1;
      BOOT_STRAP_PULLUP_EN <= 1'b1;
      ADDRESS_WIDTH_PULLUP_EN <= 1'b1;
      OSC_HIGH_SWING_SELECT <= 1'b0;
      EXT_CLOCK_MODE <= 1'b0;
    end
    else
    begin
      RESET_STATE_OUT_N <= !in_reset;
      INT_RESET_N <= !in_reset;
      BOOT_EXTERNAL <= boot_q.boot_external;
      WIDE_ADDRESS <= boot_q.wide_address;
      ADDRESS_LINES <= boot_q.wide_address ? 5'(RBCS_ADDR_LINES_WIDE)
                       : 5'(RBCS_ADDR_LINES_NARROW);
      RESET_PIN_PULLUP_EN <= !pull_off.reset_pin_pullup_off;
      BOOT_STRAP_PULLUP_EN <= !pull_off.boot_strap_pullup_off;
      ADDRESS_WIDTH_PULLUP_EN <= !pull_off.address_width_pullup_off;
      OSC_HIGH_SWING_SELECT <= osc_ctrl_q[RBCS_OSC_SWING_BIT];
      // External clock needs the mode pin and the swing bit together
      EXT_CLOCK_MODE <= clock_mode_s && osc_ctrl_q[RBCS_OSC_SWING_BIT];
    end
  end

endmodule

// file: tb_top.sv
// Testbench: reset sequencing, boot latch and register access
`timescale 1ns/1ps
module tb_top;
  import rbcs_pkg::*;
  localparam int REL = 4;
  logic clk, pin_n, rso_n, int_n, boot_ext, wide, swing, ext_mode;
  logic pu_rst, pu_boot, pu_aw;
  logic nrst = 1'b0, por_n = 1'b0, press = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic [3:0] straps = 4'h0, addr = 4'h0;
  logic [3:0] pins;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [4:0] lines;
  logic trst_n;
  logic keep_dbg = 1'b0;
  int num_errors = 0;
  int checked = 0;
  // ********************
  // Board, device and stimulus
  // ********************
  rbcs_board board (.clk(clk), .press(press), .keep_debug(keep_dbg),
    .straps(straps), .reset_pin_n(pin_n), .test_reset_n(trst_n),
    .pins(pins));
  rbcs_top #(.RELEASE_CYCLES(REL), .POR_CYCLES(2)) dut (.SYS_CLK(clk),
    .NRST(nrst), .POR_N(por_n), .RESET_PIN_N(pin_n),
    .BOOT_SOURCE_STRAP(pins[3]), .ADDRESS_WIDTH_STRAP(pins[2]),
    .FLASH_SECURED(pins[1]), .CLOCK_MODE_INPUT(pins[0]), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .RESET_STATE_OUT_N(rso_n), .INT_RESET_N(int_n),
    .BOOT_EXTERNAL(boot_ext), .WIDE_ADDRESS(wide), .ADDRESS_LINES(lines),
    .RESET_PIN_PULLUP_EN(pu_rst), .BOOT_STRAP_PULLUP_EN(pu_boot),
    .ADDRESS_WIDTH_PULLUP_EN(pu_aw), .OSC_HIGH_SWING_SELECT(swing),
    .EXT_CLOCK_MODE(ext_mode));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // Pin reset with straps s; the write under reset must be dropped
  task boot(input logic [3:0] s);
    int n;
    logic eb;
    logic ew;
    eb = s[3] && !s[1];
    ew = eb && s[2];
    @(posedge clk);
    press <= 1'b1;
    straps <= s;
    repeat (6) @(posedge clk);
    chk({15'h0, trst_n}, {15'h0, keep_dbg});
    wr(RBCS_OFF_OSC_CTRL, 16'h0001);
    @(posedge clk);
    press <= 1'b0;
    n = 0;
    while (pin_n !== 1'b1 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 9), 16'h0001);
    n = 0;
    while (int_n !== 1'b1 && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n == REL + 3), 16'h0001);
    if (n == 99)
      tally_and_finish();
    chk({3'h0, rso_n, boot_ext, wide, lines, swing, ext_mode, pu_rst,
      pu_boot, pu_aw},
      {3'h0, 1'b1, eb, ew, ew ? 5'h14 : 5'h10, 5'h07});
    rd(RBCS_OFF_OSC_CTRL, 16'h0000);
    rd(RBCS_OFF_STATUS, {11'h0, s[0], s[1], ew, eb, 1'b1});
  endtask
  task tally_and_finish;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      boot(4'(i));
    boot(4'h1);
    $display("boot table done");
    wr(RBCS_OFF_PULL_OFF, 16'h0007);
    repeat (2) @(negedge clk);
    chk({13'h0, pu_rst, pu_boot, pu_aw}, 16'h0000);
    wr(RBCS_OFF_OSC_CTRL, 16'h0001);
    repeat (3) @(negedge clk);
    chk({14'h0, swing, ext_mode}, 16'h0003);
    wr(RBCS_OFF_STATUS, 16'hffff);
    rd(RBCS_OFF_STATUS, 16'h0011);
    rd(RBCS_OFF_PULL_OFF, 16'h0007);
    rd(4'h3, 16'h0000);
    $display("register test done");
    @(posedge clk);
    por_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk({14'h0, int_n, rso_n}, 16'h0000);
    @(posedge clk);
    por_n <= 1'b1;
    keep_dbg <= 1'b1;
    boot(4'hc);
    $display("power-on test done");
    tally_and_finish();
  end
endmodule
